// File: pkg/wcqos_pkg.sv
// ****************************************************************
// walk cache and qos configuration constants
// ****************************************************************
package wcqos_pkg;

    // register byte addresses
    localparam logic [16:0] WCQOS_CTRL_ADDR = 17'h0_8e00;
    localparam logic [16:0] WCQOS_QOS_ADDR = 17'h0_8e04;
    localparam int WCQOS_MIN_ADDR_W = 17;

    // reset values
    localparam logic [31:0] WCQOS_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] WCQOS_QOS_RESET = 32'h0000_0000;

    // walk cache control fields
    localparam int WCQOS_S2_OFF_LSB = 12;
    localparam int WCQOS_S1_OFF_LSB = 8;
    localparam int WCQOS_AUX_LSB = 0;
    localparam int WCQOS_AUX_W = 8;
    localparam int WCQOS_LEVELS = 4;

    // qos fields
    localparam int WCQOS_QOS_W = 4;
    localparam int WCQOS_SYNC_LSB = 24;
    localparam int WCQOS_MSI_LSB = 20;
    localparam int WCQOS_QUEUE_LSB = 16;
    localparam int WCQOS_WALK_LSB = 0;
    localparam int WCQOS_QOS_USED_W = 28;

    // apb protection bit that marks a non-secure access
    localparam int WCQOS_PPROT_NS_BIT = 1;

    // outgoing transaction kinds on the walk master port
    typedef enum logic [1:0] {
        WCQOS_TXN_WALK,
        WCQOS_TXN_QUEUE,
        WCQOS_TXN_MSI,
        WCQOS_TXN_SYNC
    } wcqos_txn_e;

    // apb answer phases
    typedef enum logic {
        WCQOS_APB_IDLE,
        WCQOS_APB_DONE
    } wcqos_apb_e;

endpackage : wcqos_pkg

// File: logic/wcqos_regs.sv
// Contract
// - ctrl bits 15:12 turn off stage2 caches
// - ctrl bits 11:8 turn off stage1 caches
// - drive configured qos per issued transaction
// - bits 27:24 qos for sync completions
// - bits 23:20 qos for interrupt writes
// - bits 19:16 qos for queue accesses
// - walk qos chosen by node priority field
// - non-secure access gated to zero/ignored unless nonsecure_tuning_access is set
// - qos writes only with both enables clear
// - qos reflects only own type or priority
// - ctrl shares the same write lockout
`timescale 1ns/1ps
`default_nettype none

module wcqos_regs
    import wcqos_pkg::*;
#(
    parameter int ADDR_W = 17
)
(
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,

    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [2:0] pprot,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    // security and translation state
    input wire logic nonsecure_tuning_access,
    input wire logic translation_enable_s,
    input wire logic translation_enable_ns,

    // walk cache disables
    output logic [WCQOS_LEVELS-1:0] s1_cache_off,
    output logic [WCQOS_LEVELS-1:0] s2_cache_off,
    output logic [WCQOS_AUX_W-1:0] aux_ctrl,

    // walk master port request side
    input wire logic txn_valid,
    input wire logic [1:0] txn_kind,
    input wire logic [1:0] txn_walk_priority,
    output logic walk_master_port_valid,
    output logic [1:0] walk_master_port_kind,
    output logic [WCQOS_QOS_W-1:0] walk_master_port_axqos
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (ADDR_W < WCQOS_MIN_ADDR_W)
    begin : g_bad_addr_w
        $error("address width too small for register map");
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [31:0] ctrl_ff;
    logic [31:0] qos_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    wcqos_apb_e apb_state_ff;
    logic txn_valid_ff;
    logic [1:0] txn_kind_ff;
    logic [WCQOS_QOS_W-1:0] axqos_ff;
    logic [WCQOS_LEVELS-1:0] s1_off_ff;
    logic [WCQOS_LEVELS-1:0] s2_off_ff;
    logic [WCQOS_AUX_W-1:0] aux_ff;

    // ****************************************************************
    // decode
    // ****************************************************************
    logic [16:0] addr_low;
    logic hit_ctrl;
    logic hit_qos;
    logic hit_any;
    logic nonsecure;
    logic ns_blocked;
    logic write_unlocked;
    logic access_done;
    logic wr_ctrl;
    logic wr_qos;
    logic [31:0] byte_mask;
    logic [31:0] nxt_ctrl;
    logic [31:0] nxt_qos;
    logic [31:0] nxt_prdata;
    logic [31:0] qos_used_mask;
    logic [WCQOS_QOS_W-1:0] nxt_axqos;

    assign addr_low = paddr[16:0];
    assign hit_ctrl = (addr_low == WCQOS_CTRL_ADDR);
    assign hit_qos = (addr_low == WCQOS_QOS_ADDR);
    assign hit_any = hit_ctrl | hit_qos;
    assign nonsecure = pprot[WCQOS_PPROT_NS_BIT];
    assign ns_blocked = nonsecure & ~nonsecure_tuning_access;
    assign write_unlocked = ~translation_enable_s & ~translation_enable_ns;
    assign access_done = psel & penable & pready_ff;
    assign wr_ctrl = access_done & pwrite & hit_ctrl & ~ns_blocked & write_unlocked;
    assign wr_qos = access_done & pwrite & hit_qos & ~ns_blocked & write_unlocked;
    assign qos_used_mask = {{(32 - WCQOS_QOS_USED_W){1'b0}}, {WCQOS_QOS_USED_W{1'b1}}};

    always_comb
    begin
        byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
        nxt_ctrl = (ctrl_ff & ~byte_mask) | (pwdata & byte_mask);
        nxt_ctrl[31:16] = 16'h0000;
        nxt_qos = ((qos_ff & ~byte_mask) | (pwdata & byte_mask)) & qos_used_mask;
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    always_comb
    begin
        nxt_prdata = 32'h0000_0000;
        if (!ns_blocked)
        begin
            if (hit_ctrl)
            begin
                nxt_prdata = ctrl_ff;
            end
            else if (hit_qos)
            begin
                nxt_prdata = qos_ff & qos_used_mask;
            end
        end
    end

    // ****************************************************************
    // apb handshake
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            apb_state_ff <= WCQOS_APB_IDLE;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            unique case (apb_state_ff)
                WCQOS_APB_IDLE:
                begin
                    if (psel && penable)
                    begin
                        apb_state_ff <= WCQOS_APB_DONE;
                        pready_ff <= 1'b1;
                        pslverr_ff <= ~hit_any;
                        prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
                    end
                end
                WCQOS_APB_DONE:
                begin
                    apb_state_ff <= WCQOS_APB_IDLE;
                    pready_ff <= 1'b0;
                    pslverr_ff <= 1'b0;
                    prdata_ff <= 32'h0000_0000;
                end
            endcase
        end
    end

    // ****************************************************************
    // walk cache control register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= WCQOS_CTRL_RESET;
        end
        else if (clk_en && wr_ctrl)
        begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // ****************************************************************
    // transaction qos register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            qos_ff <= WCQOS_QOS_RESET;
        end
        else if (clk_en && wr_qos)
        begin
            qos_ff <= nxt_qos;
        end
    end

    // ****************************************************************
    // cache disable outputs
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_off_ff <= '0;
            s2_off_ff <= '0;
            aux_ff <= '0;
        end
        else if (clk_en)
        begin
            s2_off_ff <= ctrl_ff[WCQOS_S2_OFF_LSB +: WCQOS_LEVELS];
            s1_off_ff <= ctrl_ff[WCQOS_S1_OFF_LSB +: WCQOS_LEVELS];
            aux_ff <= ctrl_ff[WCQOS_AUX_LSB +: WCQOS_AUX_W];
        end
    end

    // ****************************************************************
    // qos selection per transaction
    // ****************************************************************
    always_comb
    begin
        nxt_axqos = '0;
        unique case (wcqos_txn_e'(txn_kind))
            WCQOS_TXN_WALK:
            begin
                nxt_axqos = qos_ff[WCQOS_WALK_LSB + WCQOS_QOS_W * txn_walk_priority
                    +: WCQOS_QOS_W];
            end
            WCQOS_TXN_QUEUE:
            begin
                nxt_axqos = qos_ff[WCQOS_QUEUE_LSB +: WCQOS_QOS_W];
            end
            WCQOS_TXN_MSI:
            begin
                nxt_axqos = qos_ff[WCQOS_MSI_LSB +: WCQOS_QOS_W];
            end
            WCQOS_TXN_SYNC:
            begin
                nxt_axqos = qos_ff[WCQOS_SYNC_LSB +: WCQOS_QOS_W];
            end
        endcase
    end

    // ****************************************************************
    // walk master port stage
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            txn_valid_ff <= 1'b0;
            txn_kind_ff <= 2'h0;
            axqos_ff <= '0;
        end
        else if (clk_en)
        begin
            txn_valid_ff <= txn_valid;
            txn_kind_ff <= txn_kind;
            axqos_ff <= txn_valid ? nxt_axqos : '0;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign s1_cache_off = s1_off_ff;
    assign s2_cache_off = s2_off_ff;
    assign aux_ctrl = aux_ff;
    assign walk_master_port_valid = txn_valid_ff;
    assign walk_master_port_kind = txn_kind_ff;
    assign walk_master_port_axqos = axqos_ff;

endmodule : wcqos_regs

`default_nettype wire

// File: verification/wcqos_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// register and port checks
// ****
module wcqos_regs_properties
    import wcqos_pkg::*;
#(
    parameter int ADDR_W = 17
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [2:0] pprot,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // security state
    input wire logic nonsecure_tuning_access,
    input wire logic translation_enable_s,
    input wire logic translation_enable_ns,
    // cache offs and walk port
    input wire logic [WCQOS_LEVELS-1:0] s1_cache_off,
    input wire logic [WCQOS_LEVELS-1:0] s2_cache_off,
    input wire logic txn_valid,
    input wire logic walk_master_port_valid,
    input wire logic [WCQOS_QOS_W-1:0] walk_master_port_axqos
);
    wire lock = translation_enable_s | translation_enable_ns;
    wire acc = psel & penable & pready;
    wire ns = pprot[WCQOS_PPROT_NS_BIT];
    wire mapped = (paddr == ADDR_W'(WCQOS_CTRL_ADDR)) || (paddr == ADDR_W'(WCQOS_QOS_ADDR));
    wire ctrl_wr = acc & pwrite & (paddr == ADDR_W'(WCQOS_CTRL_ADDR)) & ~lock & ~ns;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held over one cycle");
    chk_one_wait: assert property (psel && !penable && clk_en |=> !pready ##1 (pready || !clk_en))
        else $error("access phase not one wait state");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");
    chk_ns_gate: assert property (acc && !pwrite && ns && !nonsecure_tuning_access |-> prdata == 0)
        else $error("gated non-secure read not zero");
    chk_rsvd_zero: assert property (acc && !pwrite |-> prdata[31:28] == 4'h0)
        else $error("reserved bits read nonzero");
    chk_unmapped_err: assert property (pready |-> pslverr == !mapped)
        else $error("slave error not matching address");
    chk_cache_write: assert property (ctrl_wr && pstrb[1] |-> ##2
        ({s2_cache_off, s1_cache_off} == $past(pwdata[15:8], 2)))
        else $error("cache offs not following write");
    chk_ctrl_lock: assert property (lock [*3] |-> $stable({s2_cache_off, s1_cache_off}))
        else $error("cache offs changed while locked");
    chk_port_valid: assert property (clk_en |=> walk_master_port_valid == $past(txn_valid))
        else $error("walk port valid not one cycle later");
    chk_qos_idle: assert property (!walk_master_port_valid |-> walk_master_port_axqos == 4'h0)
        else $error("qos driven without transaction");
endmodule : wcqos_regs_properties

bind wcqos_regs wcqos_regs_properties #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nonsecure_tuning_access(nonsecure_tuning_access),
    .translation_enable_s(translation_enable_s), .translation_enable_ns(translation_enable_ns),
    .s1_cache_off(s1_cache_off), .s2_cache_off(s2_cache_off), .txn_valid(txn_valid),
    .walk_master_port_valid(walk_master_port_valid),
    .walk_master_port_axqos(walk_master_port_axqos));
`default_nettype wire

// File: verification/wcqos_ic_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// downstream interconnect
// ****
module wcqos_ic_model
    import wcqos_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // walk master port
    input wire logic walk_master_port_valid,
    input wire logic [WCQOS_QOS_W-1:0] walk_master_port_axqos,
    // observed traffic
    output logic [7:0] txn_count,
    output logic [WCQOS_QOS_W-1:0] last_axqos
);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            txn_count <= 8'h00;
            last_axqos <= 4'h0;
        end
        else if (walk_master_port_valid)
        begin
            txn_count <= txn_count + 8'h01;
            last_axqos <= walk_master_port_axqos;
        end
    end
endmodule : wcqos_ic_model
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
// ****
// bench
// ****
module testbench
    import wcqos_pkg::*;
;
    typedef struct {logic [1:0] kind; logic [1:0] prio; logic [3:0] exp;} wcqos_row_s;
    wcqos_row_s rows [7] = '{'{2'h0, 2'h0, 4'h1}, '{2'h0, 2'h1, 4'h2}, '{2'h0, 2'h2, 4'h3},
        '{2'h0, 2'h3, 4'h4}, '{2'h1, 2'h3, 4'h5}, '{2'h2, 2'h0, 4'h6}, '{2'h3, 2'h1, 4'h7}};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ns_acc = 1'b0, en_s = 1'b0, en_ns = 1'b0;
    logic txn_valid = 1'b0, pready, pslverr, valid_out;
    logic clk_en = 1'b1;
    logic [3:0] pstrb = 4'hf;
    logic [1:0] kind_out;
    logic [16:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [2:0] pprot = '0;
    logic [1:0] txn_kind = '0, txn_prio = '0;
    logic [3:0] s1_off, s2_off, axqos, last_axqos;
    logic [7:0] aux, txn_count;
    int failures = 0;
    int num_checks = 0;
    always #20 pclk = ~pclk;
    wcqos_regs dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nonsecure_tuning_access(ns_acc), .translation_enable_s(en_s),
        .translation_enable_ns(en_ns), .s1_cache_off(s1_off), .s2_cache_off(s2_off),
        .aux_ctrl(aux), .txn_valid(txn_valid), .txn_kind(txn_kind),
        .txn_walk_priority(txn_prio), .walk_master_port_valid(valid_out),
        .walk_master_port_kind(kind_out), .walk_master_port_axqos(axqos));
    wcqos_ic_model u_ic (.pclk(pclk), .presetn(presetn), .walk_master_port_valid(valid_out),
        .walk_master_port_axqos(axqos), .txn_count(txn_count), .last_axqos(last_axqos));
    task automatic end_sim();
        if (failures == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    task automatic apb(input logic w, input logic [16:0] a, input logic [31:0] d, input logic ns);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pprot <= {1'b0, ns, 1'b0};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            failures++;
            end_sim();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rdchk(input logic [16:0] a, input logic ns, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, ns);
        `CHK(rd, e)
    endtask : rdchk
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        `CHK({s2_off, s1_off, aux}, 16'h0000)
        rdchk(WCQOS_CTRL_ADDR, 1'b0, WCQOS_CTRL_RESET);
        rdchk(WCQOS_QOS_ADDR, 1'b0, WCQOS_QOS_RESET);
        apb(1'b1, WCQOS_QOS_ADDR, 32'hf765_4321, 1'b0);
        rdchk(WCQOS_QOS_ADDR, 1'b0, 32'h0765_4321);
        foreach (rows[i])
        begin
            txn_kind <= rows[i].kind;
            txn_prio <= rows[i].prio;
            txn_valid <= 1'b1;
            repeat (2) @(posedge pclk);
            `CHK(axqos, rows[i].exp)
            `CHK(kind_out, rows[i].kind)
        end
        txn_valid <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK(txn_count, 8'h0e)
        `CHK(last_axqos, 4'h7)
        apb(1'b1, WCQOS_CTRL_ADDR, 32'h0000_a500, 1'b0);
        repeat (2) @(posedge pclk);
        `CHK({s2_off, s1_off, aux}, 16'ha500)
        for (int i = 1; i < 4; i++)
        begin
            {en_ns, en_s} <= 2'(i);
            apb(1'b1, WCQOS_CTRL_ADDR, 32'h0000_0000, 1'b0);
            apb(1'b1, WCQOS_QOS_ADDR, 32'h0000_0000, 1'b0);
            rdchk(WCQOS_CTRL_ADDR, 1'b0, 32'h0000_a500);
            rdchk(WCQOS_QOS_ADDR, 1'b0, 32'h0765_4321);
        end
        {en_ns, en_s} <= 2'h0;
        apb(1'b1, WCQOS_QOS_ADDR, 32'h0000_0000, 1'b1);
        rdchk(WCQOS_QOS_ADDR, 1'b1, 32'h0000_0000);
        rdchk(WCQOS_CTRL_ADDR, 1'b1, 32'h0000_0000);
        ns_acc <= 1'b1;
        apb(1'b1, WCQOS_QOS_ADDR, 32'h0000_0008, 1'b1);
        rdchk(WCQOS_QOS_ADDR, 1'b1, 32'h0000_0008);
        rdchk(17'h0_8e08, 1'b0, 32'h0000_0000);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        `CHK({s2_off, s1_off, aux}, 16'h0000)
        rdchk(WCQOS_CTRL_ADDR, 1'b0, WCQOS_CTRL_RESET);
        rdchk(WCQOS_QOS_ADDR, 1'b0, WCQOS_QOS_RESET);
        pstrb <= 4'h8;
        apb(1'b1, WCQOS_QOS_ADDR, 32'hffff_ffff, 1'b0);
        pstrb <= 4'h2;
        apb(1'b1, WCQOS_CTRL_ADDR, 32'hffff_ffff, 1'b0);
        pstrb <= 4'hf;
        rdchk(WCQOS_QOS_ADDR, 1'b0, 32'h0f00_0000);
        rdchk(WCQOS_CTRL_ADDR, 1'b0, 32'h0000_ff00);
        `CHK({s2_off, s1_off, aux}, 16'hff00)
        clk_en <= 1'b0;
        txn_kind <= 2'h3;
        txn_valid <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK({valid_out, axqos}, 5'h00)
        clk_en <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK({valid_out, axqos}, 5'h1f)
        txn_valid <= 1'b0;
        end_sim();
    end
endmodule : testbench
`default_nettype wire
